//--- verilog/card_descriptor_pkg.sv
`default_nettype none

package card_descriptor_pkg;

	// ==========================================================
	// Descriptor geometry.
	localparam int DESC_W       = 128;
	localparam int CRC_W        = 7;
	localparam int BODY_W       = 120;
	localparam int CRC_LSB      = 1;
	localparam int STOP_BIT     = 0;

	// ==========================================================
	// Identity descriptor field positions.
	localparam int CID_MAKER_LSB  = 120;
	localparam int CID_OEM_LSB    = 104;
	localparam int CID_NAME_LSB   = 64;
	localparam int CID_REV_LSB    = 56;
	localparam int CID_SERIAL_LSB = 24;
	localparam int CID_RSVD_LSB   = 20;
	localparam int CID_YEAR_LSB   = 12;
	localparam int CID_MONTH_LSB  = 8;

	// ==========================================================
	// Card-specific descriptor field positions.
	localparam int CSD_LAYOUT_LSB   = 126;
	localparam int CSD_ACCESS_LSB   = 112;
	localparam int CSD_ACCCLK_LSB   = 104;
	localparam int CSD_TRAN_LSB     = 96;
	localparam int CSD_RDBLK_LSB    = 80;
	localparam int CSD_PARTRD_BIT   = 79;
	localparam int CSD_WRMIS_BIT    = 78;
	localparam int CSD_RDMIS_BIT    = 77;
	localparam int CSD_SIZE_LSB     = 48;
	localparam int CSD_ERASE_BIT    = 46;
	localparam int CSD_SECTOR_LSB   = 39;
	localparam int CSD_GRPSIZE_LSB  = 32;
	localparam int CSD_GRPEN_BIT    = 31;
	localparam int CSD_FACTOR_LSB   = 26;
	localparam int CSD_WRBLK_LSB    = 22;
	localparam int CSD_COPY_BIT     = 14;
	localparam int CSD_PERM_BIT     = 13;
	localparam int CSD_TEMP_BIT     = 12;

	// ==========================================================
	// Fixed field values and reset values.
	localparam logic [1:0]  LAYOUT_V2       = 2'h1;
	localparam logic [7:0]  ACCESS_TIME     = 8'h0E;
	localparam logic [7:0]  ACCESS_CLOCKS   = 8'h00;
	localparam logic [7:0]  TRAN_DEFAULT    = 8'h32;
	localparam logic [7:0]  TRAN_HIGH       = 8'h5A;
	localparam logic [7:0]  TRAN_UHS50      = 8'h0B;
	localparam logic [7:0]  TRAN_UHS104     = 8'h2B;
	localparam logic [11:0] CLASSES_DEFAULT = 12'h5B5;
	localparam logic [3:0]  BLOCK_LEN_512   = 4'h9;
	localparam logic [6:0]  SECTOR_SIZE     = 7'h7F;
	localparam logic [6:0]  GROUP_SIZE      = 7'h00;
	localparam logic [2:0]  WRITE_FACTOR    = 3'h2;
	localparam logic        ERASE_ONE       = 1'h1;
	localparam logic        FLAG_RESET      = 1'h0;
	localparam logic [6:0]  CRC_POLY        = 7'h09;

	// ==========================================================
	// Masks over the card-specific descriptor.
	localparam logic [127:0] CSD_WRITABLE = 128'h0000_0000_0000_0000_0000_0000_0000_70FE;
	localparam logic [127:0] CSD_RESERVED = 128'h3F00_0000_0000_0FC0_0000_8000_601F_0300;

	// ==========================================================
	// Bus speed modes reported by the command layer.
	typedef enum logic [2:0] {
		SPEED_DEFAULT = 3'h0,
		SPEED_HIGH    = 3'h1,
		SPEED_SDR50   = 3'h2,
		SPEED_DDR50   = 3'h3,
		SPEED_SDR104  = 3'h4
	} speed_mode_e;

endpackage

`default_nettype wire

//--- verilog/crc7_chain.sv
`default_nettype none

module crc7_chain #(
	parameter int N = 120
) (
	// Message, first bit sent in the top position
	input  wire logic [N-1:0] data,
	// Checksum
	output logic      [6:0]   crc
);

	logic [6:0] chain [0:N];

	assign chain[0] = 7'h00;

	// ==========================================================
	// One shift step of the serial checksum per message bit.
	for (genvar i = 0; i < N; i++) begin : g_step
		logic feedback;
		assign feedback     = data[N-1-i] ^ chain[i][6];
		assign chain[i + 1] = {chain[i][5:0], 1'h0} ^ ({7{feedback}} & card_descriptor_pkg::CRC_POLY);
	end

	assign crc = chain[N];

endmodule

`default_nettype wire

//--- verilog/csd_program_check.sv
`default_nettype none

module csd_program_check (
	// Present contents and proposed contents
	input  wire logic [127:0] current,
	input  wire logic [127:0] image,
	// One-time bits already spent
	input  wire logic         copyDone,
	input  wire logic         permDone,
	// Verdict
	output logic              accept,
	output logic              copyChange,
	output logic              permChange
);

	logic readOnlyClash;

	// ==========================================================
	// Any difference outside the writable bits refuses the whole image.
	assign readOnlyClash = |((current ^ image) & ~card_descriptor_pkg::CSD_WRITABLE);
	assign copyChange    = current[card_descriptor_pkg::CSD_COPY_BIT] ^ image[card_descriptor_pkg::CSD_COPY_BIT];
	assign permChange    = current[card_descriptor_pkg::CSD_PERM_BIT] ^ image[card_descriptor_pkg::CSD_PERM_BIT];
	assign accept        = !readOnlyClash && !(copyDone && copyChange) && !(permDone && permChange);

endmodule

`default_nettype wire

//--- verilog/card_descriptor_regs.sv
`default_nettype none

module card_descriptor_regs #(
	parameter logic [7:0]  MAKER_CODE    = 8'h00,          // Arbitrary value.
	parameter logic [15:0] OEM_CODE      = 16'h4142,       // Arbitrary value.
	parameter logic [39:0] PRODUCT_NAME  = 40'h4341_5244_30,
	parameter logic [7:0]  PRODUCT_REV   = 8'h10,
	parameter logic [31:0] SERIAL_NUMBER = 32'h0000_0001,
	parameter logic [7:0]  MAKE_YEAR     = 8'h00,
	parameter logic [3:0]  MAKE_MONTH    = 4'h1,
	parameter logic [21:0] DEVICE_SIZE   = 22'h00_1010,
	parameter logic        DRIVER_STAGE  = 1'h0,
	parameter logic [11:0] COMMAND_SET   = card_descriptor_pkg::CLASSES_DEFAULT
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// Descriptor read commands
	input  wire logic         identityReadReq,
	input  wire logic         specificReadReq,
	// Bus speed switch and card reset command
	input  wire logic         speedModeValid,
	input  wire logic [2:0]   speedMode,
	input  wire logic         cardResetCmd,
	// Program command
	input  wire logic         programValid,
	input  wire logic [127:0] programImage,
	// Read answer
	output logic      [127:0] readData,
	output logic              readValid,
	output logic              readIsSpecific,
	// Program answer and lock state
	output logic              programAccepted,
	output logic              programRejected,
	output logic              copyFlag,
	output logic              permanentLockBit,
	output logic              temporaryLockBit
);

	// ==========================================================
	// State.
	typedef struct packed {
		logic [127:0] readData;
		logic         readValid;
		logic         readIsSpecific;
		logic         programAccepted;
		logic         programRejected;
		logic [7:0]   tranSpeed;
		logic         copyFlag;
		logic         permLock;
		logic         tempLock;
		logic         copyDone;
		logic         permDone;
		logic         crcHeld;
		logic [6:0]   crcValue;
	} state_s;

	localparam state_s STATE_RESET = '{tranSpeed: card_descriptor_pkg::TRAN_DEFAULT, default: '0};

	state_s       state_reg;
	state_s       state_next;
	logic [119:0] identityBody;
	logic [119:0] specificBody;
	logic [6:0]   identityCrc;
	logic [6:0]   specificCrcCalc;
	logic [127:0] identityImage;
	logic [127:0] specificImage;
	logic         programOk;
	logic         copyChange;
	logic         permChange;

	// ==========================================================
	// Identity descriptor contents.
	assign identityBody = {MAKER_CODE,
		OEM_CODE,
		PRODUCT_NAME,
		PRODUCT_REV,
		SERIAL_NUMBER,
		4'h0,
		MAKE_YEAR, MAKE_MONTH};

	crc7_chain #(
		.N (card_descriptor_pkg::BODY_W)
	) u_identityCrc (
		.data (identityBody),
		.crc  (identityCrc)
	);

	assign identityImage = {identityBody, identityCrc, 1'h1};

	// ==========================================================
	// Card-specific descriptor contents.
	assign specificBody = {card_descriptor_pkg::LAYOUT_V2, 6'h00,
		card_descriptor_pkg::ACCESS_TIME, card_descriptor_pkg::ACCESS_CLOCKS,
		state_reg.tranSpeed, COMMAND_SET,
		card_descriptor_pkg::BLOCK_LEN_512,
		1'h0,
		1'h0, 1'h0,
		DRIVER_STAGE, 6'h00,
		DEVICE_SIZE,
		1'h0, card_descriptor_pkg::ERASE_ONE, card_descriptor_pkg::SECTOR_SIZE,
		card_descriptor_pkg::GROUP_SIZE, 1'h0,
		2'h0, card_descriptor_pkg::WRITE_FACTOR, card_descriptor_pkg::BLOCK_LEN_512,
		1'h0, 5'h00, 1'h0,
		state_reg.copyFlag, state_reg.permLock, state_reg.tempLock,
		2'h0, 2'h0};

	crc7_chain #(
		.N (card_descriptor_pkg::BODY_W)
	) u_specificCrc (
		.data (specificBody),
		.crc  (specificCrcCalc)
	);

	// A checksum written by the host replaces the computed one until reset.
	assign specificImage = {specificBody, state_reg.crcHeld ? state_reg.crcValue : specificCrcCalc, 1'h1};

	csd_program_check u_check (
		.current    (specificImage),
		.image      (programImage),
		.copyDone   (state_reg.copyDone),
		.permDone   (state_reg.permDone),
		.accept     (programOk),
		.copyChange (copyChange),
		.permChange (permChange)
	);

	// ==========================================================
	// Next state.
	always_comb begin
		state_next                 = state_reg;
		state_next.readValid       = 1'h0;
		state_next.programAccepted = 1'h0;
		state_next.programRejected = 1'h0;
		if (identityReadReq) begin
			state_next.readData       = identityImage;
			state_next.readValid      = 1'h1;
			state_next.readIsSpecific = 1'h0;
		end else if (specificReadReq) begin
			state_next.readData       = specificImage;
			state_next.readValid      = 1'h1;
			state_next.readIsSpecific = 1'h1;
		end
		if (cardResetCmd) begin
			state_next.tranSpeed = card_descriptor_pkg::TRAN_DEFAULT;
		end else if (speedModeValid) begin
			case (card_descriptor_pkg::speed_mode_e'(speedMode))
				card_descriptor_pkg::SPEED_DEFAULT: begin
					state_next.tranSpeed = card_descriptor_pkg::TRAN_DEFAULT;
				end
				card_descriptor_pkg::SPEED_HIGH: begin
					state_next.tranSpeed = card_descriptor_pkg::TRAN_HIGH;
				end
				card_descriptor_pkg::SPEED_SDR50, card_descriptor_pkg::SPEED_DDR50: begin
					state_next.tranSpeed = card_descriptor_pkg::TRAN_UHS50;
				end
				card_descriptor_pkg::SPEED_SDR104: begin
					state_next.tranSpeed = card_descriptor_pkg::TRAN_UHS104;
				end
				default: begin
					state_next.tranSpeed = state_reg.tranSpeed;
				end
			endcase
		end
		if (programValid) begin
			if (programOk) begin
				state_next.copyFlag        = programImage[card_descriptor_pkg::CSD_COPY_BIT];
				state_next.permLock        = programImage[card_descriptor_pkg::CSD_PERM_BIT];
				state_next.tempLock        = programImage[card_descriptor_pkg::CSD_TEMP_BIT];
				state_next.copyDone        = state_reg.copyDone | copyChange;
				state_next.permDone        = state_reg.permDone | permChange;
				state_next.crcHeld         = 1'h1;
				state_next.crcValue        = programImage[card_descriptor_pkg::CRC_LSB +: card_descriptor_pkg::CRC_W];
				state_next.programAccepted = 1'h1;
			end else begin
				state_next.programRejected = 1'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= STATE_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	assign readData         = state_reg.readData;
	assign readValid        = state_reg.readValid;
	assign readIsSpecific   = state_reg.readIsSpecific;
	assign programAccepted  = state_reg.programAccepted;
	assign programRejected  = state_reg.programRejected;
	assign copyFlag         = state_reg.copyFlag;
	assign permanentLockBit = state_reg.permLock;
	assign temporaryLockBit = state_reg.tempLock;

	// ==========================================================
	// Checks.
	logic identityOut;
	logic specificOut;

	assign identityOut = readValid && !readIsSpecific;
	assign specificOut = readValid && readIsSpecific;

	sequence s_toSdr104;
		speedModeValid && !cardResetCmd && speedMode == 3'h4;
	endsequence

	sequence s_toUhs50;
		speedModeValid && !cardResetCmd && (speedMode == 3'h2 || speedMode == 3'h3);
	endsequence

	property p_identityRead;
		@(posedge clk) disable iff (rst)
		identityReadReq |=> identityOut && readData == identityImage;
	endproperty
	a_identityRead: assert property (p_identityRead) else $error("identity read answer wrong");

	property p_identityFields;
		@(posedge clk) disable iff (rst)
		identityOut |-> readData[card_descriptor_pkg::CID_MAKER_LSB +: 8] == MAKER_CODE
			&& readData[card_descriptor_pkg::CID_SERIAL_LSB +: 32] == SERIAL_NUMBER
			&& readData[card_descriptor_pkg::CID_YEAR_LSB +: 8] == MAKE_YEAR;
	endproperty
	a_identityFields: assert property (p_identityFields) else $error("identity field misplaced");

	property p_identityTail;
		@(posedge clk) disable iff (rst)
		identityOut |-> readData[card_descriptor_pkg::CRC_LSB +: 7] == identityCrc
			&& readData[card_descriptor_pkg::STOP_BIT];
	endproperty
	a_identityTail: assert property (p_identityTail) else $error("identity checksum or end bit wrong");

	property p_reservedZero;
		@(posedge clk) disable iff (rst)
		readValid |-> (readIsSpecific ? (readData & card_descriptor_pkg::CSD_RESERVED) == 128'h0
			: readData[card_descriptor_pkg::CID_RSVD_LSB +: 4] == 4'h0);
	endproperty
	a_reservedZero: assert property (p_reservedZero) else $error("reserved bit not zero");

	property p_readOnlyHeld;
		@(posedge clk) disable iff (rst)
		programValid && ((programImage ^ specificImage) & ~card_descriptor_pkg::CSD_WRITABLE) != 128'h0
			|=> programRejected && !programAccepted && $stable(copyFlag) && $stable(temporaryLockBit);
	endproperty
	a_readOnlyHeld: assert property (p_readOnlyHeld) else $error("read-only change not refused");

	property p_permOnce;
		@(posedge clk) disable iff (rst)
		programValid && state_reg.permDone && programImage[card_descriptor_pkg::CSD_PERM_BIT] != permanentLockBit
			|=> programRejected && $stable(permanentLockBit);
	endproperty
	a_permOnce: assert property (p_permOnce) else $error("permanent lock changed twice");

	property p_layoutAccess;
		@(posedge clk) disable iff (rst)
		specificOut |-> readData[card_descriptor_pkg::CSD_LAYOUT_LSB +: 2] == 2'h1
			&& readData[card_descriptor_pkg::CSD_ACCESS_LSB +: 8] == 8'h0E
			&& readData[card_descriptor_pkg::CSD_ACCCLK_LSB +: 8] == 8'h00;
	endproperty
	a_layoutAccess: assert property (p_layoutAccess) else $error("layout or access time wrong");

	property p_uhsRate;
		@(posedge clk) disable iff (rst)
		(s_toSdr104 ##1 (!speedModeValid && !cardResetCmd) ##1 (specificReadReq && !identityReadReq))
			|=> readData[card_descriptor_pkg::CSD_TRAN_LSB +: 8] == 8'h2B;
	endproperty
	a_uhsRate: assert property (p_uhsRate) else $error("SDR104 rate not shown");

	property p_uhs50Rate;
		@(posedge clk) disable iff (rst)
		s_toUhs50 |=> state_reg.tranSpeed == 8'h0B;
	endproperty
	a_uhs50Rate: assert property (p_uhs50Rate) else $error("50 MHz class rate wrong");

	property p_resetRate;
		@(posedge clk) disable iff (rst)
		cardResetCmd |=> state_reg.tranSpeed == 8'h32;
	endproperty
	a_resetRate: assert property (p_resetRate) else $error("rate not restored by reset command");

	property p_fixedBlocks;
		@(posedge clk) disable iff (rst)
		specificOut |-> readData[card_descriptor_pkg::CSD_RDBLK_LSB +: 4] == 4'h9
			&& !readData[card_descriptor_pkg::CSD_PARTRD_BIT]
			&& !readData[card_descriptor_pkg::CSD_WRMIS_BIT] && !readData[card_descriptor_pkg::CSD_RDMIS_BIT]
			&& readData[card_descriptor_pkg::CSD_SIZE_LSB +: 22] == DEVICE_SIZE;
	endproperty
	a_fixedBlocks: assert property (p_fixedBlocks) else $error("block or size field wrong");

	property p_fixedErase;
		@(posedge clk) disable iff (rst)
		specificOut |-> readData[card_descriptor_pkg::CSD_ERASE_BIT]
			&& readData[card_descriptor_pkg::CSD_SECTOR_LSB +: 7] == 7'h7F
			&& readData[card_descriptor_pkg::CSD_GRPSIZE_LSB +: 7] == 7'h00
			&& !readData[card_descriptor_pkg::CSD_GRPEN_BIT]
			&& readData[card_descriptor_pkg::CSD_FACTOR_LSB +: 3] == 3'h2
			&& readData[card_descriptor_pkg::CSD_WRBLK_LSB +: 4] == 4'h9;
	endproperty
	a_fixedErase: assert property (p_fixedErase) else $error("erase or write field wrong");

endmodule

`default_nettype wire

//--- tb/host_cmd_model.sv
`default_nettype none

// ==========================================================
// Host side of the command bus, issuing descriptor commands.
module host_cmd_model (
	// Clock
	input  wire logic         clk,
	// Commands towards the card logic
	output var  logic         identityReadReq,
	output var  logic         specificReadReq,
	output var  logic         speedModeValid,
	output var  logic [2:0]   speedMode,
	output var  logic         cardResetCmd,
	output var  logic         programValid,
	output var  logic [127:0] programImage,
	// Answers from the card logic
	input  wire logic [127:0] readData,
	input  wire logic         readValid,
	input  wire logic         readIsSpecific,
	input  wire logic         programAccepted,
	input  wire logic         programRejected
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		identityReadReq = 1'h0;
		specificReadReq = 1'h0;
		speedModeValid  = 1'h0;
		speedMode       = 3'h0;
		cardResetCmd    = 1'h0;
		programValid    = 1'h0;
		programImage    = 128'h0;
	end

	// ==========================================================
	// Transfers.
	task automatic readDesc(input logic ident, input logic spec, output logic [129:0] ans);
		@(posedge clk);
		identityReadReq <= ident;
		specificReadReq <= spec;
		@(posedge clk);
		identityReadReq <= 1'h0;
		specificReadReq <= 1'h0;
		// The wait is a fixed count, never reckoned from the access-time fields.
		#1;
		ans = {readValid, readIsSpecific, readData};
	endtask

	task automatic setSpeed(input logic sw, input logic [2:0] mode, input logic cmdReset);
		@(posedge clk);
		speedModeValid <= sw;
		speedMode      <= mode;
		cardResetCmd   <= cmdReset;
		@(posedge clk);
		speedModeValid <= 1'h0;
		speedMode      <= ~mode;
		cardResetCmd   <= 1'h0;
	endtask

	task automatic writeProgram(input logic [127:0] img, output logic [1:0] ans);
		@(posedge clk);
		programValid <= 1'h1;
		programImage <= img;
		@(posedge clk);
		programValid <= 1'h0;
		// Released data is scrambled so a stale image cannot pass for a held one.
		programImage <= ~img;
		#1;
		ans = {programAccepted, programRejected};
	endtask

endmodule

`default_nettype wire

//--- tb/card_identity_and_specific_data_regs_tb.sv
`default_nettype none

module card_identity_and_specific_data_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// Card parameters and signals.
	localparam logic [7:0]   MAKER  = 8'hA5;        // Arbitrary value.
	localparam logic [15:0]  OEM    = 16'h5859;     // Arbitrary value.
	localparam logic [39:0]  NAME   = 40'h5445_5354_31;
	localparam logic [7:0]   REV    = 8'h62;
	localparam logic [31:0]  SERIAL = 32'hDEAD_0042;
	localparam logic [7:0]   YEAR   = 8'h01;
	localparam logic [3:0]   MONTH  = 4'h4;
	localparam logic [21:0]  SIZE   = 22'h00_FFFF;
	localparam logic         DSR    = 1'h1;
	localparam logic [127:0] WMASK  = 128'h70FE;

	logic         clk = 1'h0;
	logic         rst = 1'h1;
	logic         identityReadReq, specificReadReq, speedModeValid, cardResetCmd, programValid;
	logic [2:0]   speedMode;
	logic [127:0] programImage, readData;
	logic         readValid, readIsSpecific, programAccepted, programRejected;
	logic         copyFlag, permanentLockBit, temporaryLockBit;
	logic [7:0]   rate;
	logic         copyB, permB, tempB, copySpent, permSpent, crcHost;
	logic [6:0]   crcVal;
	logic [129:0] ans;
	logic [127:0] img;
	int           fails = 0;
	int           total_checks = 0;
	int           cycles = 0;

	always #4 clk = ~clk;

	card_descriptor_regs #(.MAKER_CODE(MAKER), .OEM_CODE(OEM), .PRODUCT_NAME(NAME), .PRODUCT_REV(REV),
		.SERIAL_NUMBER(SERIAL), .MAKE_YEAR(YEAR), .MAKE_MONTH(MONTH), .DEVICE_SIZE(SIZE),
		.DRIVER_STAGE(DSR)) i_dut (.clk(clk), .rst(rst), .identityReadReq(identityReadReq),
		.specificReadReq(specificReadReq), .speedModeValid(speedModeValid), .speedMode(speedMode),
		.cardResetCmd(cardResetCmd), .programValid(programValid), .programImage(programImage),
		.readData(readData), .readValid(readValid), .readIsSpecific(readIsSpecific),
		.programAccepted(programAccepted), .programRejected(programRejected), .copyFlag(copyFlag),
		.permanentLockBit(permanentLockBit), .temporaryLockBit(temporaryLockBit));

	host_cmd_model i_host (.clk(clk), .identityReadReq(identityReadReq), .specificReadReq(specificReadReq),
		.speedModeValid(speedModeValid), .speedMode(speedMode), .cardResetCmd(cardResetCmd),
		.programValid(programValid), .programImage(programImage), .readData(readData),
		.readValid(readValid), .readIsSpecific(readIsSpecific), .programAccepted(programAccepted),
		.programRejected(programRejected));

	// ==========================================================
	// Expected contents.
	function automatic logic [6:0] crc7(input logic [119:0] msg);
		logic [6:0] c;
		logic       fb;
		c = 7'h00;
		for (int i = 119; i >= 0; i--) begin
			fb = msg[i] ^ c[6];
			c  = {c[5:0], 1'h0} ^ (fb ? 7'h09 : 7'h00);
		end
		return c;
	endfunction

	function automatic logic [127:0] expCid();
		logic [119:0] body;
		body = {MAKER, OEM, NAME, REV, SERIAL, 4'h0, YEAR, MONTH};
		return {body, crc7(body), 1'h1};
	endfunction

	function automatic logic [127:0] expCsd();
		logic [119:0] body;
		body = {2'h1, 6'h00, 8'h0E, 8'h00, rate, 12'h5B5, 4'h9, 3'h0, DSR, 6'h00, SIZE, 2'h1, 7'h7F, 7'h00,
			1'h0, 2'h0, 3'h2, 4'h9, 1'h0, 5'h00, 1'h0, copyB, permB, tempB, 4'h0};
		return {body, crcHost ? crcVal : crc7(body), 1'h1};
	endfunction

	function automatic logic [7:0] nextRate(input logic [2:0] m, input logic [7:0] cur);
		case (m)
			3'h0: return 8'h32;
			3'h1: return 8'h5A;
			3'h2, 3'h3: return 8'h0B;
			3'h4: return 8'h2B;
			default: return cur;
		endcase
	endfunction

	// ==========================================================
	// Checking tasks.
	task automatic check(input string what, input logic [129:0] exp, input logic [129:0] got);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic doRead(input logic spec);
		i_host.readDesc(~spec, spec, ans);
		check("descriptor read", {1'h1, spec, spec ? expCsd() : expCid()}, ans);
	endtask

	task automatic tryProgram(input logic [127:0] im);
		logic [1:0] a;
		logic       ok;
		ok = (((im ^ expCsd()) & ~WMASK) == 128'h0) && !(copySpent && im[14] != copyB)
			&& !(permSpent && im[13] != permB);
		i_host.writeProgram(im, a);
		check("program answer", {ok, !ok}, a);
		if (ok) begin
			copySpent = copySpent | (im[14] != copyB);
			permSpent = permSpent | (im[13] != permB);
			{copyB, permB, tempB, crcVal, crcHost} = {im[14:12], im[7:1], 1'h1};
		end
		check("lock bits", {copyB, permB, tempB}, {copyFlag, permanentLockBit, temporaryLockBit});
	endtask

	task automatic summarize();
		$display("Checks %0d, mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles >= 5000) begin
			fails++;
			summarize();
		end
	end

	// ==========================================================
	// Main sequence.
	initial begin
		int op;
		int k;
		int md;
		void'($urandom(98772));
		{rate, copyB, permB, tempB, copySpent, permSpent, crcHost, crcVal} = {8'h32, 6'h00, 7'h00};
		repeat (4) @(posedge clk);
		rst <= 1'h0;
		doRead(1'h0);
		doRead(1'h1);
		i_host.readDesc(1'h1, 1'h1, ans);
		check("dual read", {2'h2, expCid()}, ans);
		for (int m = 0; m < 8; m++) begin
			i_host.setSpeed(1'h1, m[2:0], 1'h0);
			rate = nextRate(m[2:0], rate);
			doRead(1'h1);
		end
		// The reset command must beat a speed switch in the same cycle.
		i_host.setSpeed(1'h1, card_descriptor_pkg::SPEED_SDR104, 1'h1);
		rate = 8'h32;
		doRead(1'h1);
		tryProgram(expCsd() | 128'h6000);
		tryProgram(expCsd() & ~128'h4000);
		tryProgram(expCsd() & ~128'h2000);
		for (int n = 0; n < 300; n++) begin
			op = $urandom_range(3);
			if (op == 0) begin
				k = $urandom_range(1);
				md = $urandom_range(7);
				i_host.setSpeed(1'h1, md[2:0], k[0]);
				rate = k[0] ? 8'h32 : nextRate(md[2:0], rate);
				doRead(1'h1);
			end else if (op == 3) begin
				doRead(1'($urandom_range(1)));
			end else begin
				img = expCsd();
				img[14:12] = 3'($urandom_range(7));
				img[7:1] = 7'($urandom_range(127));
				k = $urandom_range(127);
				if (op == 2) begin
					img = img ^ ((128'h1 << k) & ~WMASK);
				end
				tryProgram(img);
			end
		end
		// A second reset clears the locks and returns the transfer rate to 8'h32.
		@(posedge clk);
		rst <= 1'h1;
		@(posedge clk);
		rst <= 1'h0;
		{rate, copyB, permB, tempB, copySpent, permSpent, crcHost} = {8'h32, 6'h00};
		doRead(1'h1);
		summarize();
	end

endmodule

`default_nettype wire
